// ===== rtl/psf_pkg.sv
// shared constants and types for the program status flags block
package psf_pkg;
    localparam logic [7:0] PSF_PSW_ADDR = 8'hd0;
    localparam logic [7:0] PSF_PSW_RESET = 8'h00;
    localparam int PSF_MIN_ADDR_W = 8;
    localparam int PSF_BIT_IDX_W = 3;
    localparam int PSF_CY_BIT = 7;
    localparam int PSF_AC_BIT = 6;
    localparam int PSF_F0_BIT = 5;
    localparam int PSF_RS1_BIT = 4;
    localparam int PSF_RS0_BIT = 3;
    localparam int PSF_OV_BIT = 2;
    localparam int PSF_F1_BIT = 1;
    localparam int PSF_PAR_BIT = 0;
    localparam logic [2:0] PSF_PAR_IDX = 3'h0;
    localparam int PSF_AC_CHAIN = 4;
    localparam int PSF_OV_CHAIN = 7;
    localparam int PSF_CY_CHAIN = 8;
    localparam logic [3:0] PSF_BCD_DIGIT_MAX = 4'h9;
    localparam logic [8:0] PSF_DA_LOW_ADJ = 9'h006;
    localparam logic [8:0] PSF_DA_HIGH_ADJ = 9'h060;
    localparam logic [8:0] PSF_ZERO9 = 9'h000;
    localparam logic [15:0] PSF_MUL_BYTE_MAX = 16'h00ff;
    localparam logic [7:0] PSF_DIV_ZERO = 8'h00;
    localparam logic [2:0] PSF_BANK_SHIFT_PAD = 3'h0;
    localparam logic [2:0] PSF_BANK_TOP_PAD = 3'h0;
    typedef enum logic [2:0] {
        PSF_OP_ADD,
        PSF_OP_ADD_WITH_CARRY_INSTR,
        PSF_OP_SUBTRACT_WITH_BORROW_INSTR,
        PSF_OP_MUL,
        PSF_OP_DIV,
        PSF_OP_DA,
        PSF_OP_COMPARE_JUMP_INSTR
    } psf_op_t;
endpackage

// ===== rtl/psf_flag_calc.sv
// combinational flag results for one datapath operation
`timescale 1ns/1ps
module psf_flag_calc (
    input wire logic i_valid,
    input wire psf_pkg::psf_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cy_now,
    input wire logic i_ac_now,
    output logic o_cy,
    output logic o_ac,
    output logic o_ov,
    output logic o_upd_cy,
    output logic o_upd_ac,
    output logic o_upd_ov
);
    // carry out of bit n-1 of a+b+c, low n bits only
    function automatic logic add_cout(input logic [7:0] a, input logic [7:0] b, input logic c, input int n);
        logic [8:0] m;
        logic [8:0] s;
        m = (9'h001 << n) - 9'h001;
        s = ({1'b0, a} & m) + ({1'b0, b} & m) + {8'h00, c};
        return s[n];
    endfunction

    // borrow out of bit n-1 of a-b-c, shows as wrap into bit n
    function automatic logic sub_bout(input logic [7:0] a, input logic [7:0] b, input logic c, input int n);
        logic [8:0] m;
        logic [8:0] s;
        m = (9'h001 << n) - 9'h001;
        s = ({1'b0, a} & m) - ({1'b0, b} & m) - {8'h00, c};
        return s[n];
    endfunction

    logic cin;
    logic [15:0] prod;
    logic da_low;
    logic da_high;
    logic [8:0] da_t;
    logic [8:0] da_t2;

    always_comb begin
        cin = (i_op == psf_pkg::PSF_OP_ADD) ? 1'b0 : i_cy_now;
        prod = {8'h00, i_a} * {8'h00, i_b};
        da_low = (i_a[3:0] > psf_pkg::PSF_BCD_DIGIT_MAX) || i_ac_now;
        da_t = {1'b0, i_a} + (da_low ? psf_pkg::PSF_DA_LOW_ADJ : psf_pkg::PSF_ZERO9);
        da_high = (da_t[7:4] > psf_pkg::PSF_BCD_DIGIT_MAX) || i_cy_now || da_t[8];
        da_t2 = {1'b0, da_t[7:0]} + (da_high ? psf_pkg::PSF_DA_HIGH_ADJ : psf_pkg::PSF_ZERO9);
        o_cy = 1'b0;
        o_ac = 1'b0;
        o_ov = 1'b0;
        o_upd_cy = 1'b0;
        o_upd_ac = 1'b0;
        o_upd_ov = 1'b0;
        if (i_valid) begin
            unique case (i_op)
                psf_pkg::PSF_OP_ADD, psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR: begin
                    o_cy = add_cout(i_a, i_b, cin, psf_pkg::PSF_CY_CHAIN);
                    o_ac = add_cout(i_a, i_b, cin, psf_pkg::PSF_AC_CHAIN);
                    o_ov = o_cy ^ add_cout(i_a, i_b, cin, psf_pkg::PSF_OV_CHAIN);
                    o_upd_cy = 1'b1;
                    o_upd_ac = 1'b1;
                    o_upd_ov = 1'b1;
                end
                psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_INSTR: begin
                    o_cy = sub_bout(i_a, i_b, cin, psf_pkg::PSF_CY_CHAIN);
                    o_ac = sub_bout(i_a, i_b, cin, psf_pkg::PSF_AC_CHAIN);
                    o_ov = o_cy ^ sub_bout(i_a, i_b, cin, psf_pkg::PSF_OV_CHAIN);
                    o_upd_cy = 1'b1;
                    o_upd_ac = 1'b1;
                    o_upd_ov = 1'b1;
                end
                psf_pkg::PSF_OP_MUL: begin
                    o_ov = prod > psf_pkg::PSF_MUL_BYTE_MAX;
                    o_upd_cy = 1'b1;
                    o_upd_ov = 1'b1;
                end
                psf_pkg::PSF_OP_DIV: begin
                    o_ov = i_b == psf_pkg::PSF_DIV_ZERO;
                    o_upd_cy = 1'b1;
                    o_upd_ov = 1'b1;
                end
                psf_pkg::PSF_OP_DA: begin
                    // a carry already set stays set: the sum was already past 99
                    o_cy = i_cy_now | da_t[8] | da_t2[8];
                    o_upd_cy = 1'b1;
                end
                psf_pkg::PSF_OP_COMPARE_JUMP_INSTR: begin
                    o_cy = i_a < i_b;
                    o_upd_cy = 1'b1;
                end
                default: begin
                    o_upd_cy = 1'b0;
                end
            endcase
        end
    end
endmodule

// ===== rtl/psf_status_word.sv
// program status word: arithmetic flags, user flags, bank select, parity
//
// Contract
// - add/subtract sets carry from msb carry/borrow
// - multiply or divide forces carry to zero
// - decimal adjust carry shows bcd sum overflow
// - compare-jump carry means first below second unsigned
// - half carry from low nibble carry/borrow
// - two user flags simply hold written values
// - bits 4,3 pick one of four banks
// - add overflow is carry6 xor carry7
// - subtract overflow is borrow6 xor borrow7
// - multiply overflow when product above 255
// - divide overflow only for zero divisor
// - parity tracks accumulator odd ones, read-only
// - register at d0, bit-addressable, resets to zero
`timescale 1ns/1ps
module psf_status_word #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [ADDR_W-1:0] i_bit_addr,
    input wire logic i_bit_val,
    input wire logic i_bit_wr,
    input wire logic i_bit_rd,
    output logic o_bit_rdata,
    input wire logic i_op_valid,
    input wire psf_pkg::psf_op_t i_op,
    input wire logic [7:0] i_opa,
    input wire logic [7:0] i_opb,
    input wire logic [7:0] i_acc,
    output logic [7:0] o_psw,
    output logic o_carry,
    output logic [1:0] o_bank_sel,
    output logic [7:0] o_bank_base
);
    if (ADDR_W < psf_pkg::PSF_MIN_ADDR_W) begin : g_addr_chk
        $error("psf_status_word: address width too small for the status register address");
    end

    localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'(psf_pkg::PSF_PSW_ADDR);

    logic [7:1] stored_r;
    logic [7:1] stored_nxt;
    logic parity_r;
    logic [7:0] rdata_r;
    logic bit_rdata_r;
    logic [7:0] word_now;
    logic reg_hit;
    logic bit_hit;
    logic [2:0] bit_idx;
    logic calc_cy;
    logic calc_ac;
    logic calc_ov;
    logic upd_cy;
    logic upd_ac;
    logic upd_ov;

    // parity is a separate flop so no write path can reach it
    assign word_now = {stored_r, parity_r};
    assign reg_hit = i_addr == REG_ADDR;
    assign bit_hit = {i_bit_addr[ADDR_W-1:psf_pkg::PSF_BIT_IDX_W], psf_pkg::PSF_BANK_SHIFT_PAD} == REG_ADDR;
    assign bit_idx = i_bit_addr[psf_pkg::PSF_BIT_IDX_W-1:0];

    psf_flag_calc u_calc (
        .i_valid(i_op_valid),
        .i_op(i_op),
        .i_a(i_opa),
        .i_b(i_opb),
        .i_cy_now(stored_r[psf_pkg::PSF_CY_BIT]),
        .i_ac_now(stored_r[psf_pkg::PSF_AC_BIT]),
        .o_cy(calc_cy),
        .o_ac(calc_ac),
        .o_ov(calc_ov),
        .o_upd_cy(upd_cy),
        .o_upd_ac(upd_ac),
        .o_upd_ov(upd_ov)
    );

    // software first, then the datapath: a flag event in the same cycle as
    // a software write is never lost
    always_comb begin
        stored_nxt = stored_r;
        if (i_wr && reg_hit) begin
            stored_nxt = i_wdata[7:1];
        end
        if (i_bit_wr && bit_hit && (bit_idx != psf_pkg::PSF_PAR_IDX)) begin
            stored_nxt[bit_idx] = i_bit_val;
        end
        if (upd_cy) begin
            stored_nxt[psf_pkg::PSF_CY_BIT] = calc_cy;
        end
        if (upd_ac) begin
            stored_nxt[psf_pkg::PSF_AC_BIT] = calc_ac;
        end
        if (upd_ov) begin
            stored_nxt[psf_pkg::PSF_OV_BIT] = calc_ov;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stored_r <= psf_pkg::PSF_PSW_RESET[7:1];
        end else begin
            stored_r <= stored_nxt;
        end
    end

    // one cycle behind the accumulator, to keep the output a flop
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            parity_r <= psf_pkg::PSF_PSW_RESET[psf_pkg::PSF_PAR_BIT];
        end else begin
            parity_r <= ^i_acc;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rdata_r <= psf_pkg::PSF_PSW_RESET;
        end else if (i_rd && reg_hit) begin
            rdata_r <= word_now;
        end else begin
            rdata_r <= psf_pkg::PSF_PSW_RESET;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            bit_rdata_r <= 1'b0;
        end else begin
            bit_rdata_r <= i_bit_rd && bit_hit && word_now[bit_idx];
        end
    end

    assign o_rdata = rdata_r;
    assign o_bit_rdata = bit_rdata_r;
    assign o_psw = word_now;
    assign o_carry = stored_r[psf_pkg::PSF_CY_BIT];
    assign o_bank_sel = stored_r[psf_pkg::PSF_RS1_BIT:psf_pkg::PSF_RS0_BIT];
    assign o_bank_base = {psf_pkg::PSF_BANK_TOP_PAD, o_bank_sel, psf_pkg::PSF_BANK_SHIFT_PAD};

    // independent reference arithmetic for the checks below
    logic chk_cin;
    logic [8:0] chk_sum9;
    logic [7:0] chk_sum7;
    logic [4:0] chk_sum4;
    logic [8:0] chk_dif9;
    logic [7:0] chk_dif7;
    logic [4:0] chk_dif4;
    logic [15:0] chk_prod;
    logic chk_is_add;

    always_comb begin
        chk_is_add = (i_op == psf_pkg::PSF_OP_ADD) || (i_op == psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR);
        chk_cin = (i_op == psf_pkg::PSF_OP_ADD) ? 1'b0 : o_carry;
        chk_sum9 = {1'b0, i_opa} + {1'b0, i_opb} + {8'h00, chk_cin};
        chk_sum7 = {1'b0, i_opa[6:0]} + {1'b0, i_opb[6:0]} + {7'h00, chk_cin};
        chk_sum4 = {1'b0, i_opa[3:0]} + {1'b0, i_opb[3:0]} + {4'h0, chk_cin};
        chk_dif9 = {1'b0, i_opa} - {1'b0, i_opb} - {8'h00, chk_cin};
        chk_dif7 = {1'b0, i_opa[6:0]} - {1'b0, i_opb[6:0]} - {7'h00, chk_cin};
        chk_dif4 = {1'b0, i_opa[3:0]} - {1'b0, i_opb[3:0]} - {4'h0, chk_cin};
        chk_prod = {8'h00, i_opa} * {8'h00, i_opb};
    end

    a_add_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && chk_is_add) |=> (o_carry == $past(chk_sum9[8])))
        else $error("carry wrong after add");

    a_sub_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && i_op == psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_INSTR) |=> (o_carry == $past(chk_dif9[8])))
        else $error("carry wrong after subtract");

    a_muldiv_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && (i_op == psf_pkg::PSF_OP_MUL || i_op == psf_pkg::PSF_OP_DIV)) |=> !o_carry)
        else $error("carry not cleared by multiply or divide");

    a_da_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && i_op == psf_pkg::PSF_OP_DA && (o_carry || i_opa > 8'h99)) |=> o_carry)
        else $error("decimal adjust lost carry");

    a_cmp_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && i_op == psf_pkg::PSF_OP_COMPARE_JUMP_INSTR) |=> (o_carry == $past(i_opa < i_opb)))
        else $error("compare carry wrong");

    a_half_add: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && chk_is_add) |=> (o_psw[psf_pkg::PSF_AC_BIT] == $past(chk_sum4[4])))
        else $error("half carry wrong after add");

    a_half_sub: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && i_op == psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_INSTR) |=> (o_psw[psf_pkg::PSF_AC_BIT] == $past(chk_dif4[4])))
        else $error("half borrow wrong after subtract");

    a_user_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!(i_wr && reg_hit) && !(i_bit_wr && bit_hit)) |=>
        $stable({o_psw[psf_pkg::PSF_F0_BIT], o_psw[psf_pkg::PSF_F1_BIT], o_bank_sel}))
        else $error("user or bank bits changed without a write");

    a_user_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr && reg_hit && !i_bit_wr) |=> (o_psw[7:1] & 7'h1d) == ($past(i_wdata[7:1]) & 7'h1d))
        else $error("written user or bank bits not kept");

    a_bank_base: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr && reg_hit && !i_bit_wr) |=> (o_bank_base == {3'h0, $past(i_wdata[4:3]), 3'h0}))
        else $error("bank base does not follow bank select");

    a_ov_add: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && chk_is_add) |=> (o_psw[psf_pkg::PSF_OV_BIT] == $past(chk_sum9[8] ^ chk_sum7[7])))
        else $error("overflow wrong after add");

    a_ov_sub: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && i_op == psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_INSTR) |=>
        (o_psw[psf_pkg::PSF_OV_BIT] == $past(chk_dif9[8] ^ chk_dif7[7])))
        else $error("overflow wrong after subtract");

    a_ov_mul: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && i_op == psf_pkg::PSF_OP_MUL) |=> (o_psw[psf_pkg::PSF_OV_BIT] == $past(chk_prod > 16'h00ff)))
        else $error("overflow wrong after multiply");

    a_ov_div: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && i_op == psf_pkg::PSF_OP_DIV) |=> (o_psw[psf_pkg::PSF_OV_BIT] == $past(i_opb == 8'h00)))
        else $error("overflow wrong after divide");

    a_parity_track: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> (o_psw[0] == $past(^i_acc)))
        else $error("parity does not follow accumulator");

    a_reset_clear: assert property (@(posedge i_clk_sys)
        i_rst |=> (o_psw[7:1] == 7'h00 && o_bank_base == 8'h00))
        else $error("status word not cleared by reset");

    a_read_back: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && reg_hit) |=> (o_rdata[7:1] == $past(o_psw[7:1])))
        else $error("register read does not return status word");

    // read data stands one cycle only, zero otherwise
    a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(i_rd && reg_hit) |=> (o_rdata == 8'h00))
        else $error("read data not zero outside a read");

    a_read_parity: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && reg_hit) |=> (o_rdata[0] == $past(o_psw[0])))
        else $error("read does not return current parity");

    a_bit_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_bit_rd && bit_hit) |=> (o_bit_rdata == $past(word_now[bit_idx])))
        else $error("bit read returns wrong value");

    a_bit_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(i_bit_rd && bit_hit) |=> !o_bit_rdata)
        else $error("bit read data set outside a bit read");

    // only checked without a datapath op, which may own the same flag
    a_bit_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_bit_wr && bit_hit && (bit_idx != psf_pkg::PSF_PAR_IDX) && !i_op_valid) |=>
        (o_psw[$past(bit_idx)] == $past(i_bit_val)))
        else $error("bit write not applied");

    a_ac_untouched: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && (i_op == psf_pkg::PSF_OP_MUL || i_op == psf_pkg::PSF_OP_DIV ||
        i_op == psf_pkg::PSF_OP_DA || i_op == psf_pkg::PSF_OP_COMPARE_JUMP_INSTR) && !i_wr && !i_bit_wr) |=>
        $stable(o_psw[psf_pkg::PSF_AC_BIT]))
        else $error("half carry changed by an op that keeps it");

    a_ov_untouched: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && (i_op == psf_pkg::PSF_OP_DA || i_op == psf_pkg::PSF_OP_COMPARE_JUMP_INSTR) && !i_wr && !i_bit_wr) |=>
        $stable(o_psw[psf_pkg::PSF_OV_BIT]))
        else $error("overflow changed by an op that keeps it");

    a_wr_elsewhere: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr && !reg_hit && !i_bit_wr && !i_op_valid) |=> $stable(o_psw[7:1]))
        else $error("write to another address changed the status word");

    a_idle_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!i_wr && !i_bit_wr && !i_op_valid) |=> $stable(o_psw[7:1]))
        else $error("stored bits changed with no write or op");

    a_reset_reads: assert property (@(posedge i_clk_sys)
        i_rst |=> (o_rdata == 8'h00 && !o_bit_rdata))
        else $error("read outputs not cleared by reset");
endmodule

// ===== bench/psf_alu_model.sv
// datapath partner model: issues flag-affecting operations and holds the accumulator
`timescale 1ns/1ps
module psf_alu_model (
    input wire logic i_clk_sys,
    output logic o_op_valid,
    output psf_pkg::psf_op_t o_op,
    output logic [7:0] o_opa,
    output logic [7:0] o_opb,
    output logic [7:0] o_acc
);
    initial begin
        o_op_valid = 1'b0;
        o_op = psf_pkg::PSF_OP_ADD;
        o_opa = 8'h00;
        o_opb = 8'h00;
        o_acc = 8'h00;
    end
    // one completion pulse per call; operands inverted afterwards so stale values never look valid
    task automatic issue(input psf_pkg::psf_op_t op, input logic [7:0] a, input logic [7:0] b);
        @(posedge i_clk_sys);
        o_op_valid <= 1'b1;
        o_op <= op;
        o_opa <= a;
        o_opb <= b;
        @(posedge i_clk_sys);
        o_op_valid <= 1'b0;
        o_opa <= ~a;
        o_opb <= ~b;
        #1;
    endtask
    task automatic set_acc(input logic [7:0] v);
        @(posedge i_clk_sys);
        o_acc <= v;
    endtask
endmodule

// ===== bench/program_status_flags_tb.sv
// self-checking bench for the program status word
`timescale 1ns/1ps
module program_status_flags_tb;
    typedef struct {
        logic [7:0] init;
        psf_pkg::psf_op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] exp;
    } psf_row_t;
    // init value, operation, operands, expected word with parity bit left as zero
    psf_row_t rows [0:17] = '{
        '{8'h00, psf_pkg::PSF_OP_ADD, 8'hff, 8'h01, 8'hc0},
        '{8'h00, psf_pkg::PSF_OP_ADD, 8'h7f, 8'h01, 8'h44},
        '{8'ha2, psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR, 8'h00, 8'h00, 8'h22},
        '{8'h80, psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR, 8'h7f, 8'h00, 8'h44},
        '{8'h00, psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_INSTR, 8'h00, 8'h01, 8'hc0},
        '{8'h00, psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_INSTR, 8'h80, 8'h01, 8'h44},
        '{8'h80, psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_INSTR, 8'h05, 8'h05, 8'hc0},
        '{8'hc4, psf_pkg::PSF_OP_MUL, 8'h10, 8'h10, 8'h44},
        '{8'h80, psf_pkg::PSF_OP_MUL, 8'h0f, 8'h11, 8'h00},
        '{8'h80, psf_pkg::PSF_OP_DIV, 8'h10, 8'h00, 8'h04},
        '{8'h84, psf_pkg::PSF_OP_DIV, 8'h10, 8'h02, 8'h00},
        '{8'h00, psf_pkg::PSF_OP_DA, 8'h9a, 8'h00, 8'h80},
        '{8'h04, psf_pkg::PSF_OP_DA, 8'h45, 8'h00, 8'h04},
        '{8'h80, psf_pkg::PSF_OP_DA, 8'h45, 8'h00, 8'h80},
        '{8'h00, psf_pkg::PSF_OP_COMPARE_JUMP_INSTR, 8'h01, 8'h02, 8'h80},
        '{8'h80, psf_pkg::PSF_OP_COMPARE_JUMP_INSTR, 8'h02, 8'h01, 8'h00},
        '{8'h80, psf_pkg::PSF_OP_COMPARE_JUMP_INSTR, 8'h05, 8'h05, 8'h00},
        '{8'h80, psf_pkg::psf_op_t'(3'h7), 8'hff, 8'hff, 8'h80}
    };
    logic clk_sys, rst, wr, rd, bit_val, bit_wr, bit_rd;
    logic [7:0] addr, wdata, bit_addr;
    wire logic [7:0] rdata, program_status_word, bank_base, opa, opb, acc;
    wire logic bit_rdata, carry, op_valid;
    wire logic [1:0] bank_sel;
    wire psf_pkg::psf_op_t op;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] v;

    psf_alu_model u_alu (.i_clk_sys(clk_sys), .o_op_valid(op_valid), .o_op(op), .o_opa(opa), .o_opb(opb),
        .o_acc(acc));
    psf_status_word #(.ADDR_W(8)) u_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_bit_addr(bit_addr), .i_bit_val(bit_val), .i_bit_wr(bit_wr),
        .i_bit_rd(bit_rd), .o_bit_rdata(bit_rdata), .i_op_valid(op_valid), .i_op(op), .i_opa(opa), .i_opb(opb),
        .i_acc(acc), .o_psw(program_status_word), .o_carry(carry), .o_bank_sel(bank_sel), .o_bank_base(bank_base));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // the whole run is under two hundred cycles; this only catches a hang
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // every bus task ends just after the sampling edge, with that edge's effects visible
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask
    task automatic wr_bit(input logic [7:0] a, input logic val);
        @(posedge clk_sys);
        bit_wr <= 1'b1;
        bit_addr <= a;
        bit_val <= val;
        @(posedge clk_sys);
        bit_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_bit(input logic [7:0] a, input logic exp);
        @(posedge clk_sys);
        bit_rd <= 1'b1;
        bit_addr <= a;
        @(posedge clk_sys);
        bit_rd <= 1'b0;
        #1;
        chk("bit_rdata", {7'h00, exp}, {7'h00, bit_rdata});
    endtask

    initial begin
        rst = 1'b1;
        {wr, rd, bit_val, bit_wr, bit_rd} = 5'h00;
        {addr, wdata, bit_addr} = 24'h000000;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(psf_pkg::PSF_PSW_ADDR, 8'h00);
        @(posedge clk_sys);
        #1;
        chk("rdata idle", 8'h00, rdata);
        wr_reg(8'hd1, 8'hff);
        rd_reg(8'hd1, 8'h00);
        rd_reg(psf_pkg::PSF_PSW_ADDR, 8'h00);
        for (int n = 0; n < 4; n++) begin
            wr_reg(psf_pkg::PSF_PSW_ADDR, 8'(n << 3));
            chk("bank_sel", 8'(n), {6'h00, bank_sel});
            chk("bank_base", 8'(n * 8), bank_base);
        end
        for (int i = 0; i < 18; i++) begin
            wr_reg(psf_pkg::PSF_PSW_ADDR, rows[i].init);
            u_alu.issue(rows[i].op, rows[i].a, rows[i].b);
            chk("psw flags", rows[i].exp, {program_status_word[7:1], 1'b0});
            chk("carry", {7'h00, rows[i].exp[7]}, {7'h00, carry});
        end
        wr_reg(psf_pkg::PSF_PSW_ADDR, 8'h00);
        wr_bit(8'hd5, 1'b1);
        wr_bit(8'hd1, 1'b1);
        wr_bit(8'hd9, 1'b1);
        chk("user flags", 8'h22, program_status_word);
        rd_bit(8'hd5, 1'b1);
        wr_bit(8'hd5, 1'b0);
        chk("user flag clear", 8'h02, program_status_word);
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 8'h01 : (k == 1) ? 8'h03 : (k == 2) ? 8'h80 : 8'hfe;
            u_alu.set_acc(v);
            @(posedge clk_sys);
            #1;
            chk("parity", {7'h00, ^v}, {7'h00, program_status_word[0]});
        end
        wr_reg(psf_pkg::PSF_PSW_ADDR, 8'h00);
        wr_bit(8'hd0, 1'b0);
        chk("parity read only", 8'h01, program_status_word);
        rd_reg(psf_pkg::PSF_PSW_ADDR, 8'h01);
        wr_reg(psf_pkg::PSF_PSW_ADDR, 8'hfa);
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("psw after reset", 8'h00, {program_status_word[7:1], 1'b0});
        chk("base after reset", 8'h00, bank_base);
        rd_bit(8'hd5, 1'b0);
        stop_test();
    end
endmodule
